// >>> dv/occ_link_model.sv
// far-side model of the comm link and digital input activation lines
`timescale 1ns/1ps
`default_nettype none
module occ_link_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic comm_req,
  input  wire logic di_req,
  input  wire logic slow,
  output logic      maint_comm,
  output logic      maint_di_pin
);
  logic comm_d;
  logic di_d;

  // requests show one cycle late, or two cycles late when slow
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comm_d       <= 1'b0;
      di_d         <= 1'b0;
      maint_comm   <= 1'b0;
      maint_di_pin <= 1'b0;
    end else begin
      comm_d       <= comm_req;
      di_d         <= di_req;
      maint_comm   <= slow ? comm_d : comm_req;
      maint_di_pin <= slow ? di_d : di_req;
    end
  end
endmodule : occ_link_model
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the output contact service block
`timescale 1ns/1ps
`default_nettype none
`include "occ_defs.svh"
module testbench;
  logic        clk, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, logic_in = 8'h00, latched_in = 8'h00, hold_in = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        remote_cfg = 1'b0, nv_maint_in = 1'b0, boot_done = 1'b0, prot_running = 1'b0;
  logic        phase_seq_calc = 1'b0, comm_req = 1'b0, di_req = 1'b0, slow = 1'b0;
  logic        pready, pslverr, err, maint_comm, maint_di_pin, trip_cmd, reboot_req;
  logic        maint_active, maint_inactive, nv_maint_out, nv_maint_we, phase_mismatch;
  logic        healthy_green, irq;
  logic [7:0]  contact_out;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  time         rel_t = 0;

  occ_ctrl #(.N_CONT(8), .ZONE_IDX(6), .SUPV_IDX(7)) occ_ctrl_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .logic_in(logic_in),
    .latched_in(latched_in), .hold_in(hold_in), .remote_cfg(remote_cfg), .maint_comm(maint_comm),
    .maint_di_pin(maint_di_pin), .nv_maint_in(nv_maint_in), .boot_done(boot_done),
    .prot_running(prot_running), .phase_seq_calc(phase_seq_calc), .contact_out(contact_out),
    .trip_cmd(trip_cmd), .reboot_req(reboot_req), .maint_active(maint_active),
    .maint_inactive(maint_inactive), .nv_maint_out(nv_maint_out), .nv_maint_we(nv_maint_we),
    .phase_mismatch(phase_mismatch), .healthy_green(healthy_green), .irq(irq));
  occ_link_model occ_link_model_inst (.clk(clk), .reset(reset), .comm_req(comm_req),
    .di_req(di_req), .slow(slow), .maint_comm(maint_comm), .maint_di_pin(maint_di_pin));

  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // one apb transfer; an idle edge first if the last one just released
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    if ($time == rel_t)
      @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1); // pready high ends this wait; the hang guard ends a stuck one
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    rel_t = $time;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rdc

  task automatic wait_maint(input logic exp);
    int n;
    n = 0;
    while (maint_active !== exp && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("maint wait", maint_active, exp);
  endtask : wait_maint

  // reset values and an unmapped access
  task automatic t_regs();
    rdc("ctrl", `OCC_A_CTRL, 32'h0);
    rdc("istat", `OCC_A_ISTAT, 32'h0);
    apb(1'b0, 8'h2C, 32'h0);
    check("unmapped err", err, 32'h1);
    check("unmapped data", rd, 32'h0);
  endtask : t_regs

  // disarm with latched, held and exempt contacts
  task automatic t_disarm();
    logic_in <= 8'hFF;
    latched_in <= 8'h01;
    hold_in <= 8'h02;
    wr(`OCC_A_CTRL, 32'h01);
    tick(2);
    check("control only", contact_out, 32'hFF);
    wr(`OCC_A_CTRL, 32'h03);
    tick(2);
    check("disarmed", contact_out, 32'hC3);
    rdc("dis stat", `OCC_A_STAT, 32'h003C0000);
    latched_in <= 8'h00;
    tick(2);
    check("unlatched", contact_out, 32'hC2);
    wr(`OCC_A_CTRL, 32'h00);
    hold_in <= 8'h00;
  endtask : t_disarm

  // single, group and disarmed forcing
  task automatic t_force();
    logic_in <= 8'h00;
    wr(`OCC_A_FVAL, 32'hA5);
    wr(`OCC_A_FSEL, 32'h0F);
    wr(`OCC_A_CTRL, 32'h08);
    tick(2);
    check("single", contact_out, 32'h05);
    wr(`OCC_A_CTRL, 32'h68);
    tick(2);
    check("group high", contact_out, 32'hFF);
    wr(`OCC_A_CTRL, 32'h28);
    tick(2);
    check("group low", contact_out, 32'h00);
    wr(`OCC_A_CTRL, 32'h6B);
    tick(2);
    check("disarm wins", contact_out, 32'hC0);
    wr(`OCC_A_CTRL, 32'h00);
  endtask : t_force

  // timed disarm and force with interrupt raise, mask and clear
  task automatic t_timed();
    logic_in <= 8'hFF;
    wr(`OCC_A_DTIME, 32'h3);
    wr(`OCC_A_IEN, 32'h1);
    wr(`OCC_A_CTRL, 32'h07);
    tick(2);
    check("tdis on", contact_out, 32'hC0);
    tick(3);
    check("tdis last", contact_out, 32'hC0);
    tick(1);
    check("tdis off", contact_out, 32'hFF);
    check("irq set", irq, 32'h1);
    rdc("ctrl cleared", `OCC_A_CTRL, 32'h05);
    rdc("dis event", `OCC_A_ISTAT, 32'h01);
    wr(`OCC_A_IEN, 32'h0);
    tick(1);
    check("irq masked", irq, 32'h0);
    wr(`OCC_A_IEN, 32'h1);
    wr(`OCC_A_ICLR, 32'h1);
    tick(1);
    check("irq cleared", irq, 32'h0);
    logic_in <= 8'h00;
    wr(`OCC_A_FTIME, 32'h2);
    wr(`OCC_A_FSEL, 32'h1);
    wr(`OCC_A_FVAL, 32'h1);
    wr(`OCC_A_CTRL, 32'h18);
    tick(2);
    check("tfrc on", contact_out, 32'h01);
    tick(2);
    check("tfrc last", contact_out, 32'h01);
    tick(1);
    check("tfrc off", contact_out, 32'h00);
    rdc("frc event", `OCC_A_ISTAT, 32'h02);
  endtask : t_timed

  // maintenance sources, refusals, outputs and restore
  task automatic t_maint();
    wr(`OCC_A_ICLR, 32'h3F);
    wr(`OCC_A_MAINT, 32'h4);
    tick(2);
    check("nv we", nv_maint_we, 32'h1);
    check("nv value", nv_maint_out, 32'h1);
    check("manual on", maint_active, 32'h1);
    check("inactive low", maint_inactive, 32'h0);
    tick(1);
    check("nv we end", nv_maint_we, 32'h0);
    wr(`OCC_A_MAINT, 32'h5);
    rdc("src kept", `OCC_A_MAINT, 32'h4);
    remote_cfg <= 1'b1;
    wr(`OCC_A_MAINT, 32'h0);
    rdc("remote refused", `OCC_A_MAINT, 32'h4);
    rdc("refusal events", `OCC_A_ISTAT, 32'h2C);
    remote_cfg <= 1'b0;
    wr(`OCC_A_MAINT, 32'h0);
    wait_maint(1'b0);
    check("inactive high", maint_inactive, 32'h1);
    wr(`OCC_A_MAINT, 32'h3);
    rdc("src code 3 ignored", `OCC_A_MAINT, 32'h0);
    wr(`OCC_A_MAINT, 32'h1);
    slow <= 1'b1;
    comm_req <= 1'b1;
    wait_maint(1'b1);
    wr(`OCC_A_MAINT, 32'h0);
    rdc("comm kept", `OCC_A_MAINT, 32'h1);
    comm_req <= 1'b0;
    wait_maint(1'b0);
    wr(`OCC_A_MAINT, 32'h2);
    slow <= 1'b0;
    di_req <= 1'b1;
    wait_maint(1'b1);
    di_req <= 1'b0;
    wait_maint(1'b0);
    nv_maint_in <= 1'b1;
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(3);
    check("nv restore", maint_active, 32'h1);
    nv_maint_in <= 1'b0;
  endtask : t_maint

  // trip and reboot one-cycle pulses
  task automatic t_cmd();
    for (int k = 0; k < 2; k++) begin
      wr(`OCC_A_CMD, 32'h1 << k);
      tick(1);
      check("pulse", {reboot_req, trip_cmd}, 32'h1 << k);
      tick(1);
      check("pulse end", {reboot_req, trip_cmd}, 32'h0);
    end
  endtask : t_cmd

  // phase sequence mismatch and healthy indicator
  task automatic t_phase();
    phase_seq_calc <= 1'b1;
    boot_done <= 1'b1;
    wr(`OCC_A_CTRL, 32'h80);
    tick(2);
    check("phase match", phase_mismatch, 32'h0);
    check("not healthy", healthy_green, 32'h0);
    wr(`OCC_A_ICLR, 32'h3F);
    phase_seq_calc <= 1'b0;
    prot_running <= 1'b1;
    tick(2);
    check("phase differs", phase_mismatch, 32'h1);
    check("healthy", healthy_green, 32'h1);
    apb(1'b0, `OCC_A_ISTAT, 32'h0);
    check("phase event", rd[4], 32'h1);
  endtask : t_phase

  // main sequence
  initial begin
    tick(10);
    check("reset contacts", contact_out, 32'h0);
    check("reset inactive", maint_inactive, 32'h1);
    reset <= 1'b0;
    tick(2);
    t_regs();
    t_disarm();
    t_force();
    t_timed();
    t_maint();
    t_cmd();
    t_phase();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire

// >>> hdl/occ_ctrl.sv
// service control of relay output contacts, forcing, trip and maintenance mode
// Behaviour
// RL1 - a whole contact group can be disarmed so no switching reaches outputs
// RL2 - zone interlocking output and supervision contact are never disarmed
// RL3 - disarm is permanent or timed; timed disarm ends by itself on expiry
// RL4 - disarm needs unlatched, no hold timer, disarm control active, disarm command
// RL5 - latched or hold-timed contacts stay armed despite a disarm request
// RL6 - force is permanent or timed; timed force ends by itself on expiry
// RL7 - group-wide force wins over single contact force
// RL8 - a disarmed contact ignores any force
// RL9 - forced position applies only when not disarmed and force command given
// RL10 - maintenance from panel, link or input; manual refused from remote tool
// RL11 - maintenance state is kept in non-volatile storage
// RL12 - source change refused while current source activation is asserted
// RL13 - complementary maintenance active and inactive outputs
// RL14 - operator request issues a trip command
// RL15 - status flags phase sequence differing from its setting
// RL16 - operator request causes a full reboot
// RL17 - healthy indicator only after boot with protection running
// RL18 - timed periods count clock ticks down and clear at zero
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "occ_defs.svh"
module occ_ctrl
  import occ_pkg::*;
#(
  parameter int unsigned N_CONT   = 8,
  parameter int unsigned ZONE_IDX = 6,
  parameter int unsigned SUPV_IDX = 7
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_CONT-1:0] logic_in,
  input  wire logic [N_CONT-1:0] latched_in,
  input  wire logic [N_CONT-1:0] hold_in,
  input  wire logic              remote_cfg,
  input  wire logic              maint_comm,
  input  wire logic              maint_di_pin,
  input  wire logic              nv_maint_in,
  input  wire logic              boot_done,
  input  wire logic              prot_running,
  input  wire logic              phase_seq_calc,
  output logic      [N_CONT-1:0] contact_out,
  output logic                   trip_cmd,
  output logic                   reboot_req,
  output logic                   maint_active,
  output logic                   maint_inactive,
  output logic                   nv_maint_out,
  output logic                   nv_maint_we,
  output logic                   phase_mismatch,
  output logic                   healthy_green,
  output logic                   irq
);
  // refuse shapes the logic cannot serve
  if (N_CONT < 1 || N_CONT > 16 || ZONE_IDX >= N_CONT || SUPV_IDX >= N_CONT) begin : g_chk
    $error("occ_ctrl: contact count or exempt index out of range");
  end

  localparam logic [N_CONT-1:0] EXEMPT = (N_CONT'(1) << ZONE_IDX) | (N_CONT'(1) << SUPV_IDX);

  // register decode, used by read and write paths
  function automatic logic occ_mapped(input logic [7:0] a);
    occ_mapped = (a[1:0] == 2'b00) && (a <= `OCC_A_CMD);
  endfunction : occ_mapped

  logic [`OCC_CTRL_W-1:0] ctrl_r;
  logic [N_CONT-1:0]      fval_r;
  logic [N_CONT-1:0]      fsel_r;
  logic [31:0]            dtime_r;
  logic [31:0]            ftime_r;
  occ_src_e               src_r;
  logic                   man_r;
  logic                   maint_r;
  logic                   init_r;
  logic                   di_s1_r;
  logic                   di_s2_r;
  logic [N_CONT-1:0]      dis_r;
  logic [`OCC_N_EV-1:0]   istat_r;
  logic [`OCC_N_EV-1:0]   ien_r;
  logic [`OCC_N_EV-1:0]   ev;
  logic [N_CONT-1:0]      dis_nxt;
  logic [N_CONT-1:0]      out_nxt;
  logic [31:0]            rdata_nxt;
  logic                   wr;
  logic                   wr_ctrl;
  logic                   wr_maint;
  logic                   act_sig;
  logic                   src_change;
  logic                   src_rej;
  logic                   man_rej;
  logic                   d_run;
  logic                   d_exp;
  logic                   f_run;
  logic                   f_exp;
  logic                   mism_nxt;

  // apb handshake, zero wait states
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !occ_mapped(paddr);
  assign wr       = psel && penable && pwrite && occ_mapped(paddr);
  assign wr_ctrl  = wr && (paddr == `OCC_A_CTRL);
  assign wr_maint = wr && (paddr == `OCC_A_MAINT);

  // control register; hardware ends timed commands on expiry
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `OCC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata[`OCC_CTRL_W-1:0];
    end else begin
      if (d_exp) ctrl_r[`OCC_C_DIS_CMD] <= 1'b0; // see RL3
      if (f_exp) ctrl_r[`OCC_C_FRC_CMD] <= 1'b0; // see RL6
    end
  end

  // force values, force selection and timed durations
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fval_r  <= '0;
      fsel_r  <= '0;
      dtime_r <= `OCC_TIME_RST;
      ftime_r <= `OCC_TIME_RST;
    end else if (wr) begin
      if (paddr == `OCC_A_FVAL)  fval_r  <= pwdata[N_CONT-1:0];
      if (paddr == `OCC_A_FSEL)  fsel_r  <= pwdata[N_CONT-1:0];
      if (paddr == `OCC_A_DTIME) dtime_r <= pwdata;
      if (paddr == `OCC_A_FTIME) ftime_r <= pwdata;
    end
  end

  // disarm timer, started by a timed disarm command rising
  occ_timer u_dis_tmr (
    .clk     (clk),
    .reset   (reset),
    .start   (wr_ctrl && pwdata[`OCC_C_DIS_CMD] && pwdata[`OCC_C_DIS_TMD] && !ctrl_r[`OCC_C_DIS_CMD]),
    .stop    (wr_ctrl && !(pwdata[`OCC_C_DIS_CMD] && pwdata[`OCC_C_DIS_TMD])),
    .dur     (dtime_r),
    .running (d_run),
    .expire  (d_exp)
  );

  // force timer, started by a timed force command rising
  occ_timer u_frc_tmr (
    .clk     (clk),
    .reset   (reset),
    .start   (wr_ctrl && pwdata[`OCC_C_FRC_CMD] && pwdata[`OCC_C_FRC_TMD] && !ctrl_r[`OCC_C_FRC_CMD]),
    .stop    (wr_ctrl && !(pwdata[`OCC_C_FRC_CMD] && pwdata[`OCC_C_FRC_TMD])),
    .dur     (ftime_r),
    .running (f_run),
    .expire  (f_exp)
  );

  // per contact disarm and force path
  for (genvar i = 0; i < N_CONT; i++) begin : g_cont
    logic sel;
    logic val;
    assign dis_nxt[i] = ctrl_r[`OCC_C_DIS_CTRL] && ctrl_r[`OCC_C_DIS_CMD] // see RL1, RL4
                        && !latched_in[i] && !hold_in[i]                 // see RL5
                        && !EXEMPT[i];                                    // see RL2
    assign sel = ctrl_r[`OCC_C_GRP_FRC] || fsel_r[i];                    // see RL7
    assign val = ctrl_r[`OCC_C_GRP_FRC] ? ctrl_r[`OCC_C_GRP_VAL] : fval_r[i];
    assign out_nxt[i] = dis_nxt[i] ? 1'b0                                // see RL8
                      : (ctrl_r[`OCC_C_FRC_CMD] && sel) ? val : logic_in[i]; // see RL9
  end

  // registered contact outputs and disarm state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dis_r       <= '0;
      contact_out <= '0;
    end else begin
      dis_r       <= dis_nxt;
      contact_out <= out_nxt;
    end
  end

  // digital input synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      di_s1_r <= 1'b0;
      di_s2_r <= 1'b0;
    end else begin
      di_s1_r <= maint_di_pin;
      di_s2_r <= di_s1_r;
    end
  end

  // activation signal of the selected source
  always_comb begin
    unique case (src_r)
      OCC_SRC_MANUAL: act_sig = man_r;
      OCC_SRC_COMM:   act_sig = maint_comm;
      OCC_SRC_DI:     act_sig = di_s2_r;
      default:        act_sig = 1'b0;
    endcase
  end

  assign src_change = wr_maint && (pwdata[1:0] != src_r) && (pwdata[1:0] != 2'b11);
  assign src_rej    = src_change && act_sig; // see RL12
  assign man_rej    = wr_maint && remote_cfg && (pwdata[`OCC_M_MAN] != man_r); // see RL10

  // source selection and manual request; restore manual level once after reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_r <= OCC_SRC_MANUAL;
      man_r <= 1'b0;
    end else if (!init_r) begin
      man_r <= nv_maint_in; // see RL11
    end else if (wr_maint) begin
      if (src_change && !act_sig) src_r <= occ_src_e'(pwdata[1:0]); // see RL12
      if (!remote_cfg) man_r <= pwdata[`OCC_M_MAN]; // see RL10
    end
  end

  // maintenance state, restored from storage then following its source
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      init_r       <= 1'b0;
      maint_r      <= 1'b0;
      nv_maint_out <= 1'b0;
      nv_maint_we  <= 1'b0;
    end else begin
      init_r       <= 1'b1;
      maint_r      <= init_r ? act_sig : nv_maint_in;
      nv_maint_out <= act_sig;
      nv_maint_we  <= init_r && (act_sig != maint_r); // see RL11
    end
  end

  assign maint_active   = maint_r;  // see RL13
  assign maint_inactive = !maint_r; // see RL13

  // phase sequence, health, trip and reboot outputs
  assign mism_nxt = phase_seq_calc != ctrl_r[`OCC_C_PHS_SET];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_mismatch <= 1'b0;
      healthy_green  <= 1'b0;
      trip_cmd       <= 1'b0;
      reboot_req     <= 1'b0;
    end else begin
      phase_mismatch <= mism_nxt;                    // see RL15
      healthy_green  <= boot_done && prot_running;   // see RL17
      trip_cmd       <= wr && (paddr == `OCC_A_CMD) && pwdata[`OCC_K_TRIP];   // see RL14
      reboot_req     <= wr && (paddr == `OCC_A_CMD) && pwdata[`OCC_K_REBOOT]; // see RL16
    end
  end

  // events into sticky status; a new event wins over a clear
  always_comb begin
    ev = '0;
    ev[`OCC_E_DEXP] = d_exp;
    ev[`OCC_E_FEXP] = f_exp;
    ev[`OCC_E_MCHG] = init_r && (act_sig != maint_r);
    ev[`OCC_E_SREJ] = src_rej;
    ev[`OCC_E_PHS]  = mism_nxt && !phase_mismatch;
    ev[`OCC_E_MREJ] = man_rej;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      istat_r <= `OCC_EV_RST;
      ien_r   <= `OCC_EV_RST;
    end else begin
      if (wr && paddr == `OCC_A_IEN) ien_r <= pwdata[`OCC_N_EV-1:0];
      istat_r <= (istat_r & ~((wr && paddr == `OCC_A_ICLR) ? pwdata[`OCC_N_EV-1:0] : '0)) | ev;
    end
  end

  assign irq = |(istat_r & ien_r);

  // read mux; clear and command registers read as zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    unique case (paddr)
      `OCC_A_CTRL:  rdata_nxt[`OCC_CTRL_W-1:0] = ctrl_r;
      `OCC_A_FVAL:  rdata_nxt[N_CONT-1:0] = fval_r;
      `OCC_A_FSEL:  rdata_nxt[N_CONT-1:0] = fsel_r;
      `OCC_A_DTIME: rdata_nxt = dtime_r;
      `OCC_A_FTIME: rdata_nxt = ftime_r;
      `OCC_A_MAINT: rdata_nxt[`OCC_M_MAN:0] = {man_r, src_r};
      `OCC_A_STAT: begin
        rdata_nxt[`OCC_S_MAINT]   = maint_r;
        rdata_nxt[`OCC_S_DRUN]    = d_run;
        rdata_nxt[`OCC_S_FRUN]    = f_run;
        rdata_nxt[`OCC_S_PHS]     = phase_mismatch;
        rdata_nxt[`OCC_S_HEALTHY] = healthy_green;
        rdata_nxt[`OCC_S_DIS +: N_CONT] = dis_r;
      end
      `OCC_A_ISTAT: rdata_nxt[`OCC_N_EV-1:0] = istat_r;
      `OCC_A_IEN:   rdata_nxt[`OCC_N_EV-1:0] = ien_r;
      default:      rdata_nxt = 32'h00000000;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= rdata_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_EXEMPT: assert property (!dis_r[ZONE_IDX] && !dis_r[SUPV_IDX]) // see RL2
    else $error("exempt contact was disarmed");
  AST_ARMED_HELD: assert property (1'b1 |=> (dis_r & $past(latched_in | hold_in)) == '0) // see RL5
    else $error("latched or held contact was disarmed");
  AST_DIS_CAUSE: assert property (|dis_r |-> $past(ctrl_r[`OCC_C_DIS_CTRL] && ctrl_r[`OCC_C_DIS_CMD])) // see RL4
    else $error("contact disarmed without control and command");
  AST_DIS_QUIET: assert property ((contact_out & dis_r) == '0) // see RL1, RL8
    else $error("disarmed contact drove its output");
  AST_DIS_EXPIRE: assert property (d_exp && !wr_ctrl |=> !ctrl_r[`OCC_C_DIS_CMD] ##1 dis_r == '0) // see RL3
    else $error("timed disarm did not end on expiry");
  AST_FRC_EXPIRE: assert property (f_exp && !wr_ctrl |=> !ctrl_r[`OCC_C_FRC_CMD]) // see RL6
    else $error("timed force did not end on expiry");
  AST_GRP_WINS: assert property (ctrl_r[`OCC_C_FRC_CMD] && ctrl_r[`OCC_C_GRP_FRC] && !dis_nxt[0]
    |=> contact_out[0] == $past(ctrl_r[`OCC_C_GRP_VAL])) // see RL7, RL9
    else $error("group force not applied");
  AST_SRC_LOCK: assert property ($changed(src_r) |-> $past(!act_sig)) // see RL12
    else $error("source changed while activation asserted");
  AST_MAINT_PAIR: assert property (maint_active != maint_inactive) // see RL13
    else $error("maintenance outputs not complementary");
  AST_TRIP: assert property (wr && paddr == `OCC_A_CMD && pwdata[`OCC_K_TRIP] |=> trip_cmd ##1 !trip_cmd) // see RL14
    else $error("trip request not issued");
  AST_PHASE: assert property (1'b1 |=> phase_mismatch == $past(mism_nxt)) // see RL15
    else $error("phase mismatch flag wrong");
  AST_HEALTHY: assert property (healthy_green |-> $past(boot_done && prot_running)) // see RL17
    else $error("healthy lit before boot and protection");

  COV_DISARM: cover property (|dis_r);
  COV_FORCE: cover property (ctrl_r[`OCC_C_FRC_CMD] ##1 f_exp);
  COV_MAINT: cover property ($rose(maint_r));
  COV_SREJ: cover property (src_rej);
endmodule : occ_ctrl
`default_nettype wire

// >>> hdl/occ_defs.svh
// register offsets, field positions, reset values for the output contact service block
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH
// register byte offsets
`define OCC_A_CTRL   8'h00
`define OCC_A_FVAL   8'h04
`define OCC_A_FSEL   8'h08
`define OCC_A_DTIME  8'h0C
`define OCC_A_FTIME  8'h10
`define OCC_A_MAINT  8'h14
`define OCC_A_STAT   8'h18
`define OCC_A_ISTAT  8'h1C
`define OCC_A_IEN    8'h20
`define OCC_A_ICLR   8'h24
`define OCC_A_CMD    8'h28
// control register fields
`define OCC_C_DIS_CTRL 0
`define OCC_C_DIS_CMD  1
`define OCC_C_DIS_TMD  2
`define OCC_C_FRC_CMD  3
`define OCC_C_FRC_TMD  4
`define OCC_C_GRP_FRC  5
`define OCC_C_GRP_VAL  6
`define OCC_C_PHS_SET  7
`define OCC_CTRL_W     8
// maintenance register fields
`define OCC_M_SRC      0
`define OCC_M_MAN      2
// one-shot command fields
`define OCC_K_TRIP     0
`define OCC_K_REBOOT   1
// status register fields
`define OCC_S_MAINT    0
`define OCC_S_DRUN     1
`define OCC_S_FRUN     2
`define OCC_S_PHS      3
`define OCC_S_HEALTHY  4
`define OCC_S_DIS      16
// event bits
`define OCC_E_DEXP     0
`define OCC_E_FEXP     1
`define OCC_E_MCHG     2
`define OCC_E_SREJ     3
`define OCC_E_PHS      4
`define OCC_E_MREJ     5
`define OCC_N_EV       6
// reset values
`define OCC_CTRL_RST   8'h00
`define OCC_TIME_RST   32'h00000000
`define OCC_EV_RST     6'h00
`endif

// >>> hdl/occ_pkg.sv
// types shared by the output contact service block
package occ_pkg;
  // maintenance mode activation source
  typedef enum logic [1:0] {
    OCC_SRC_MANUAL,
    OCC_SRC_COMM,
    OCC_SRC_DI
  } occ_src_e;
  typedef logic [31:0] occ_word_t;
endpackage : occ_pkg

// >>> hdl/occ_timer.sv
// countdown timer for timed disarm and timed force
`timescale 1ns/1ps
`default_nettype none
module occ_timer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [31:0] dur,
  output logic             running,
  output logic             expire
);
  logic [31:0] cnt_r;

  // load on start, count one per tick, expire on reaching zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r   <= 32'h00000000;
      running <= 1'b0;
      expire  <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin
        cnt_r   <= dur;
        running <= (dur != 32'h00000000);
        expire  <= (dur == 32'h00000000);
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        cnt_r <= cnt_r - 32'h00000001; // see RL18
        if (cnt_r == 32'h00000001) begin
          running <= 1'b0;
          expire  <= 1'b1; // see RL18
        end
      end
    end
  end

  AST_TMR_ZERO: assert property (@(posedge clk) disable iff (reset)
    running && !start && !stop && cnt_r == 32'h00000001 |=> expire && !running) // see RL18
    else $error("timer did not expire when count reached zero");
endmodule : occ_timer
`default_nettype wire
